// >>> serial_eeprom_program_control.sv
// Serial EEPROM core: enable latch, self-timed erase and write, status
// Assumes a 40 MHz ref_clk_i and a host that drives chip select and clock
//
// Operation
// - Power-up leaves programming disabled; erase and write refused until enabled.
// - Programming stays enabled until a disable instruction or power loss.
// - Reads behave identically whether programming is enabled or not.
// - Word erase sets every bit of the addressed word to one.
// - Chip select fall after a complete erase starts the timed cycle.
// - After 250 ns low then high, output shows busy low, ready high; left undriven if the rise comes after the cycle has ended.
// - Word erase lasts 4 ms.
// - Chip select fall after a write starts erase then program of word.
// - Word write including its erase lasts 4 ms.
// - Erase-all sets whole array to ones in 8 ms from select fall.
// - Timed cycles finish with no further serial clock pulses.
// - Write-all erases then fills array in 16 ms; needs enable.
// - Select high selects; a started cycle finishes regardless of select.
// - Select low at least 250 ns between instructions; low resets control.
// - Bits sampled and output bits updated on rising serial clock.
// - Serial clock may stop at either level and resume later.
// - Clock ignored while deselected or waiting for the start bit.
// - Exact clock count per instruction; afterwards inputs ignored until restart.
// - No status if select stays constant; otherwise output high impedance.
// - Word size select high gives 16-bit words, low gives 8-bit.
// - Start bit is first rising edge with select and data high.
// - Opcodes 10 read, 01 write, 11 erase, 00 uses address top bits.
// - Read gives dummy zero then words MSB first, continuing while selected.
`timescale 1ns/1ps
`include "serial_eeprom_map.svh"

module serial_eeprom_program_control #(
  parameter int unsigned WORD_CYC = `EE_WORD_CYC,
  parameter int unsigned ERASE_ALL_CMD_CYC = `EE_ERASE_ALL_CMD_CYC,
  parameter int unsigned WRITE_ALL_CMD_CYC = `EE_WRITE_ALL_CMD_CYC
) (
  // Clocks and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic sclk_i,
  // Serial pins
  input  wire logic cs_i,
  input  wire logic serial_in_i,
  input  wire logic word_size_sel_i,
  output logic      serial_out_o,
  output logic      serial_out_oe_o
);

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  serial_eeprom_pkg::core_t q, d;
  logic [8:0]               rd_addr;
  logic                     rd_bit;
  logic                     rd_oe;
  logic                     link_done;
  logic [25:0]              sreg;
  logic [3:0]               hdr;
  logic [15:0]              rd_full;
  logic [15:0]              rd_word;

  // Array is quiet during reads, so the link reads it without a crossing
  assign rd_full = q.mem[serial_eeprom_pkg::word_idx(rd_addr, q.org_s)];
  assign rd_word = q.org_s ? rd_full : {8'h00, rd_addr[0] ? rd_full[15:8] : rd_full[7:0]};

  serial_link_front u_link (
    .sclk_i      (sclk_i),
    .cs_i        (cs_i),
    .serial_in_i (serial_in_i),
    .word16_i    (q.org_s),
    .rd_word_i   (rd_word),
    .rd_addr_o   (rd_addr),
    .rd_bit_o    (rd_bit),
    .rd_oe_o     (rd_oe),
    .done_o      (link_done),
    .sreg_o      (sreg),
    .hdr_o       (hdr)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic        cs_fall;
  logic        cs_rise;
  logic        busy;
  logic        take;
  logic [8:0]  c_addr;
  logic [15:0] c_data;
  logic [7:0]  c_idx;
  logic [7:0]  b_idx;
  logic [15:0] fill;

  assign cs_fall = q.cs_p & ~q.cs_s;
  assign cs_rise = ~q.cs_p & q.cs_s;
  assign busy    = (q.phase == serial_eeprom_pkg::PG_BUSY);
  assign take    = cs_fall & q.armed & ~busy;
  assign c_addr  = serial_eeprom_pkg::cmd_addr(sreg, q.org_s, serial_eeprom_pkg::has_data(hdr));
  assign c_data  = q.org_s ? sreg[15:0] : {8'h00, sreg[7:0]};
  assign c_idx   = serial_eeprom_pkg::word_idx(c_addr, q.org_s);
  assign b_idx   = serial_eeprom_pkg::word_idx(q.addr, q.org_s);
  assign fill    = q.org_s ? q.data : {q.data[7:0], q.data[7:0]};

  // Places a word or a byte into the stored word
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic word_size_sel, input logic hi);
    if (word_size_sel)
      return nw;
    return hi ? {nw[7:0], old[7:0]} : {old[15:8], nw[7:0]};
  endfunction : merge

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  always_comb
  begin
    d        = q;
    d.cs_m   = cs_i;
    d.cs_s   = q.cs_m;
    d.cs_p   = q.cs_s;
    d.done_m = link_done;
    d.done_s = q.done_m;
    d.org_m  = word_size_sel_i;
    d.org_s  = q.org_m;
    // Done and select travel separate chains, so hold done until select falls
    d.armed  = q.cs_s & (q.armed | q.done_s);
    if (q.cs_s)
      d.low_cnt = 4'h0;
    else if (q.low_cnt != 4'hf)
      d.low_cnt = q.low_cnt + 4'h1;
    if (!q.cs_s)
      d.stat_oe = 1'b0;
    else if (cs_rise && busy && q.low_cnt >= 4'(`EE_TCSL_CYC))
      d.stat_oe = 1'b1;
    unique case (q.phase)
      serial_eeprom_pkg::PG_IDLE:
        if (take)
        begin
          d.addr = c_addr;
          d.data = c_data;
          unique case (hdr[3:2])
            `EE_OP_READ:
              d.addr = c_addr;
            `EE_OP_ERASE:
              if (q.prog_en)
              begin
                d.phase      = serial_eeprom_pkg::PG_BUSY;
                d.kind       = serial_eeprom_pkg::PK_ERASE;
                d.timer      = 20'(WORD_CYC);
                d.mem[c_idx] = merge(q.mem[c_idx], 16'hffff, q.org_s, c_addr[0]);
              end
            `EE_OP_WRITE:
              if (q.prog_en)
              begin
                d.phase      = serial_eeprom_pkg::PG_BUSY;
                d.kind       = serial_eeprom_pkg::PK_WRITE;
                d.timer      = 20'(WORD_CYC);
                d.mem[c_idx] = merge(q.mem[c_idx], 16'hffff, q.org_s, c_addr[0]);
              end
            `EE_OP_SPECIAL:
              unique case (hdr[1:0])
                `EE_SUB_ENABLE:
                  d.prog_en = 1'b1;
                `EE_SUB_DISABLE:
                  d.prog_en = 1'b0;
                `EE_SUB_ER_ALL:
                  if (q.prog_en)
                  begin
                    d.phase = serial_eeprom_pkg::PG_BUSY;
                    d.kind  = serial_eeprom_pkg::PK_ERASE_ALL;
                    d.timer = 20'(ERASE_ALL_CMD_CYC);
                    d.mem   = '1;
                  end
                `EE_SUB_WR_ALL:
                  if (q.prog_en)
                  begin
                    d.phase = serial_eeprom_pkg::PG_BUSY;
                    d.kind  = serial_eeprom_pkg::PK_WRITE_ALL;
                    d.timer = 20'(WRITE_ALL_CMD_CYC);
                    d.mem   = '1;
                  end
              endcase
          endcase
        end
      serial_eeprom_pkg::PG_BUSY:
      begin
        // Runs on the reference clock alone, whatever select does meanwhile
        d.timer = q.timer - `EE_TIMER_ONE;
        if (q.timer == `EE_TIMER_ONE)
        begin
          d.phase = serial_eeprom_pkg::PG_IDLE;
          if (q.kind == serial_eeprom_pkg::PK_WRITE)
            d.mem[b_idx] = merge(q.mem[b_idx], q.data, q.org_s, q.addr[0]);
          if (q.kind == serial_eeprom_pkg::PK_WRITE_ALL)
            d.mem = {`EE_WORDS{fill}};
        end
      end
    endcase
    d.ready = (d.phase == serial_eeprom_pkg::PG_IDLE);
    if (reset_i)
    begin
      d       = '0;
      d.mem   = '1;
      d.ready = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    q <= d;
  end

  // ----------------------------------------------------------------
  // Data output
  // ----------------------------------------------------------------
  // Read bits must follow the serial clock, status the reference clock
  assign serial_out_o    = rd_oe ? rd_bit : q.ready;
  assign serial_out_oe_o = rd_oe | q.stat_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  localparam logic [3:0] DISABLE_HDR = {`EE_OP_SPECIAL, `EE_SUB_DISABLE};
  localparam logic [3:0] TCSL4       = 4'(`EE_TCSL_CYC);
  localparam logic [3:0] ENABLE_HDR  = {`EE_OP_SPECIAL, `EE_SUB_ENABLE};

  chk_start_needs_en:
    assert property ($rose(busy) |-> $past(q.prog_en))
      else $error("programming started while disabled");

  chk_en_holds:
    assert property (q.prog_en && !(take && hdr == DISABLE_HDR) |=> q.prog_en)
      else $error("enable latch dropped without disable");

  chk_refused_cmd:
    assert property (take && !q.prog_en |=> !busy ##1 !busy)
      else $error("cycle started while disabled");

  chk_erase_ones:
    assert property ($rose(busy) && q.kind == serial_eeprom_pkg::PK_ERASE |->
                     (q.mem[b_idx] | (q.org_s ? 16'h0000 : (q.addr[0] ? 16'h00ff : 16'hff00)))
                     == 16'hffff)
      else $error("erased word not all ones");

  chk_erase_time:
    assert property ($rose(busy) && q.kind == serial_eeprom_pkg::PK_ERASE |->
                     q.timer == 20'(WORD_CYC))
      else $error("erase cycle length wrong");

  chk_write_time:
    assert property ($rose(busy) && q.kind == serial_eeprom_pkg::PK_WRITE |->
                     q.timer == 20'(WORD_CYC))
      else $error("write cycle length wrong");

  chk_erase_all_cmd_time:
    assert property ($rose(busy) && q.kind == serial_eeprom_pkg::PK_ERASE_ALL |->
                     q.timer == 20'(ERASE_ALL_CMD_CYC) && q.mem == '1)
      else $error("erase-all cycle wrong");

  chk_write_all_cmd_time:
    assert property ($rose(busy) && q.kind == serial_eeprom_pkg::PK_WRITE_ALL |->
                     q.timer == 20'(WRITE_ALL_CMD_CYC))
      else $error("write-all cycle length wrong");

  chk_cycle_ends:
    assert property (busy |=> busy == ($past(q.timer) != `EE_TIMER_ONE))
      else $error("cycle did not end on its count");

  chk_status_shows:
    assert property (cs_rise && busy && q.low_cnt >= TCSL4 |=>
                     serial_out_oe_o && (rd_oe || serial_out_o == q.ready))
      else $error("status not shown after select pulse");

  chk_status_off:
    assert property (!q.cs_s |=> !q.stat_oe)
      else $error("status driven while deselected");

  chk_short_low:
    assert property (cs_rise && q.low_cnt < TCSL4 |=> !q.stat_oe)
      else $error("status after too short a low");

  chk_reset_state:
    assert property ($fell(reset_i) |-> !q.prog_en && !busy)
      else $error("reset left programming enabled");

  chk_en_sets:
    assert property (take && hdr == ENABLE_HDR |=> q.prog_en)
      else $error("enable instruction ignored");

  chk_dis_clears:
    assert property (take && hdr == DISABLE_HDR |=> !q.prog_en)
      else $error("disable instruction ignored");

  chk_refused_mem:
    assert property (take && !q.prog_en |=> $stable(q.mem))
      else $error("array changed while disabled");

  // Byte-wide storage is left to the read-back in the bench
  chk_write_erases:
    assert property ($rose(busy) && q.kind == serial_eeprom_pkg::PK_WRITE && q.org_s |->
                     q.mem[b_idx] == 16'hffff)
      else $error("word not erased before write");

  chk_write_lands:
    assert property (busy && q.timer == `EE_TIMER_ONE && q.org_s &&
                     q.kind == serial_eeprom_pkg::PK_WRITE |=>
                     q.mem[$past(b_idx)] == $past(q.data))
      else $error("written word not stored");

  chk_write_all_cmd_fill:
    assert property (busy && q.timer == `EE_TIMER_ONE &&
                     q.kind == serial_eeprom_pkg::PK_WRITE_ALL |=>
                     q.mem == {`EE_WORDS{$past(fill)}})
      else $error("write-all data not stored");

  chk_cycle_holds:
    assert property (busy && q.timer != `EE_TIMER_ONE |=>
                     busy && $stable(q.kind) && $stable(q.addr))
      else $error("running cycle disturbed");

  chk_ready_end:
    assert property (busy && q.timer == `EE_TIMER_ONE |=> q.ready)
      else $error("ready not shown after cycle");

  chk_busy_low:
    assert property (busy && q.stat_oe && !rd_oe |-> !serial_out_o)
      else $error("busy not shown low");

  chk_read_quiet:
    assert property (!cs_i |-> !rd_oe)
      else $error("read data while deselected");

  cov_write_start:
    cover property ($rose(busy) && q.kind == serial_eeprom_pkg::PK_WRITE);
  cov_write_all_cmd_start:
    cover property ($rose(busy) && q.kind == serial_eeprom_pkg::PK_WRITE_ALL);
  cov_status_busy:
    cover property ($rose(q.stat_oe) && busy);
  cov_read_out:
    cover property ($rose(rd_oe));
  cov_erase_all_cmd_start:
    cover property ($rose(busy) && q.kind == serial_eeprom_pkg::PK_ERASE_ALL);
endmodule : serial_eeprom_program_control

// >>> serial_eeprom_map.svh
// Constant map for the serial EEPROM programming controller
// Assumes a 40 MHz reference clock and a host-driven serial clock
`ifndef SERIAL_EEPROM_MAP_SVH
`define SERIAL_EEPROM_MAP_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EE_REF_NS       25
`define EE_TCSL_NS      250
`define EE_TCSL_CYC     ((`EE_TCSL_NS + `EE_REF_NS - 1) / `EE_REF_NS)
`define EE_WORD_NS      4000000
`define EE_ERASE_ALL_CMD_NS      8000000
`define EE_WRITE_ALL_CMD_NS      16000000
`define EE_WORD_CYC     (`EE_WORD_NS / `EE_REF_NS)
`define EE_ERASE_ALL_CMD_CYC     (`EE_ERASE_ALL_CMD_NS / `EE_REF_NS)
`define EE_WRITE_ALL_CMD_CYC     (`EE_WRITE_ALL_CMD_NS / `EE_REF_NS)
`define EE_TIMER_ONE    20'h00001

// ----------------------------------------------------------------
// Instruction coding
// ----------------------------------------------------------------
`define EE_OP_SPECIAL   2'h0
`define EE_OP_WRITE     2'h1
`define EE_OP_READ      2'h2
`define EE_OP_ERASE     2'h3
`define EE_SUB_DISABLE  2'h0
`define EE_SUB_WR_ALL   2'h1
`define EE_SUB_ER_ALL   2'h2
`define EE_SUB_ENABLE   2'h3

// ----------------------------------------------------------------
// Field lengths
// ----------------------------------------------------------------
`define EE_HDR_CNT      5'h04
`define EE_OP_W         5'h02
`define EE_ADDR_W16     5'h08
`define EE_ADDR_W8      5'h09
`define EE_DATA_W16     5'h10
`define EE_DATA_W8      5'h08
`define EE_MSB_W16      4'hf
`define EE_MSB_W8       4'h7
`define EE_MASK_W16     9'h0ff
`define EE_MASK_W8      9'h1ff
`define EE_WORDS        256

`endif

// >>> serial_eeprom_pkg.sv
// Types and decode helpers shared by the EEPROM controller files
// Assumes serial_eeprom_map.svh is on the include path
package serial_eeprom_pkg;
`include "serial_eeprom_map.svh"

  typedef enum logic [1:0] {LK_WAIT, LK_SHIFT, LK_READ, LK_DONE} link_phase_t;
  typedef enum logic [1:0] {PK_ERASE, PK_WRITE, PK_ERASE_ALL, PK_WRITE_ALL} prog_kind_t;
  typedef enum logic {PG_IDLE, PG_BUSY} prog_phase_t;

  typedef struct packed {
    link_phase_t phase;
    logic [4:0]  cnt;
    logic [8:0]  rd_addr;
    logic [3:0]  rd_idx;
    logic        rd_oe;
    logic        rd_bit;
    logic        done;
  } link_ctl_t;

  typedef struct packed {
    logic [25:0] sreg;
    logic [3:0]  hdr;
  } link_data_t;

  typedef struct packed {
    logic                             cs_m, cs_s, cs_p;
    logic                             done_m, done_s;
    logic                             org_m, org_s;
    logic                             armed, prog_en, stat_oe, ready;
    prog_phase_t                      phase;
    prog_kind_t                       kind;
    logic [19:0]                      timer;
    logic [3:0]                       low_cnt;
    logic [8:0]                       addr;
    logic [15:0]                      data;
    logic [`EE_WORDS-1:0][15:0]       mem;
  } core_t;

  function automatic logic has_data(input logic [3:0] hdr);
    return (hdr[3:2] == `EE_OP_WRITE) ||
           (hdr[3:2] == `EE_OP_SPECIAL && hdr[1:0] == `EE_SUB_WR_ALL);
  endfunction : has_data

  function automatic logic [4:0] instr_len(input logic [3:0] hdr, input logic word_size_sel);
    logic [4:0] a;
    logic [4:0] dl;
    a  = word_size_sel ? `EE_ADDR_W16 : `EE_ADDR_W8;
    dl = has_data(hdr) ? (word_size_sel ? `EE_DATA_W16 : `EE_DATA_W8) : 5'h00;
    return 5'(`EE_OP_W + a + dl);
  endfunction : instr_len

  function automatic logic [8:0] cmd_addr(input logic [25:0] sreg, input logic word_size_sel,
                                          input logic hd);
    logic [25:0] s;
    s = hd ? (word_size_sel ? (sreg >> `EE_DATA_W16) : (sreg >> `EE_DATA_W8)) : sreg;
    return word_size_sel ? {1'b0, s[7:0]} : s[8:0];
  endfunction : cmd_addr

  function automatic logic [7:0] word_idx(input logic [8:0] a, input logic word_size_sel);
    return word_size_sel ? a[7:0] : a[8:1];
  endfunction : word_idx
endpackage : serial_eeprom_pkg

// >>> serial_link_front.sv
// Serial front end running on the host's serial clock
// Assumes chip select is a clean pin; it clears the control state at once
`timescale 1ns/1ps
module serial_link_front (
  // Serial pins
  input  wire logic        sclk_i,
  input  wire logic        cs_i,
  input  wire logic        serial_in_i,
  // From the core
  input  wire logic        word16_i,
  input  wire logic [15:0] rd_word_i,
  // To the core
  output logic      [8:0]  rd_addr_o,
  output logic             rd_bit_o,
  output logic             rd_oe_o,
  output logic             done_o,
  output logic      [25:0] sreg_o,
  output logic      [3:0]  hdr_o
);
`include "serial_eeprom_map.svh"

  serial_eeprom_pkg::link_ctl_t  q, d;
  serial_eeprom_pkg::link_data_t dq, dd;
  logic [3:0]                    msb;

  assign msb = word16_i ? `EE_MSB_W16 : `EE_MSB_W8;

  // ----------------------------------------------------------------
  // Instruction sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    d  = q;
    dd = dq;
    unique case (q.phase)
      serial_eeprom_pkg::LK_WAIT:
        if (serial_in_i)
          d.phase = serial_eeprom_pkg::LK_SHIFT;
      serial_eeprom_pkg::LK_SHIFT:
      begin
        dd.sreg = {dq.sreg[24:0], serial_in_i};
        d.cnt   = q.cnt + 5'h01;
        if (d.cnt == `EE_HDR_CNT)
          dd.hdr = dd.sreg[3:0];
        if (d.cnt >= `EE_HDR_CNT && d.cnt == serial_eeprom_pkg::instr_len(dd.hdr, word16_i))
        begin
          // Read runs the same whatever the enable latch holds
          if (dd.hdr[3:2] == `EE_OP_READ)
          begin
            d.phase   = serial_eeprom_pkg::LK_READ;
            d.rd_oe   = 1'b1;
            d.rd_bit  = 1'b0;
            d.rd_addr = serial_eeprom_pkg::cmd_addr(dd.sreg, word16_i, 1'b0);
            d.rd_idx  = msb;
          end
          else
          begin
            d.phase = serial_eeprom_pkg::LK_DONE;
            d.done  = 1'b1;
          end
        end
      end
      serial_eeprom_pkg::LK_READ:
      begin
        d.rd_bit = rd_word_i[q.rd_idx];
        if (q.rd_idx == 4'h0)
        begin
          d.rd_idx  = msb;
          d.rd_addr = (q.rd_addr + 9'h001) & (word16_i ? `EE_MASK_W16 : `EE_MASK_W8);
        end
        else
          d.rd_idx = q.rd_idx - 4'h1;
      end
      serial_eeprom_pkg::LK_DONE:
        d.phase = serial_eeprom_pkg::LK_DONE;
    endcase
  end

  // Clock may stop at any level; nothing here counts on a free-running edge
  always_ff @(posedge sclk_i or negedge cs_i)
  begin
    if (!cs_i)
      q <= '0;
    else
      q <= d;
  end

  // Command bits survive the chip select fall so the core can still read them
  always_ff @(posedge sclk_i)
  begin
    dq <= dd;
  end

  assign rd_addr_o = q.rd_addr;
  assign rd_bit_o  = q.rd_bit;
  assign rd_oe_o   = q.rd_oe;
  assign done_o    = q.done;
  assign sreg_o    = dq.sreg;
  assign hdr_o     = dq.hdr;
endmodule : serial_link_front

// >>> serial_host_model.sv
// Host model: drives chip select, serial clock and data in, samples the data pin
// Assumes the bench resolves the data pin with a pull-up when it is not driven
`timescale 1ns/1ps
module serial_host_model (
  // Serial pins
  output logic      sclk_o,
  output logic      cs_o,
  output logic      serial_in_o,
  input  wire logic pin_i,
  // Sample strobe towards the bench
  output logic      got_stb_o,
  output logic      got_bit_o
);
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  initial
  begin
    sclk_o      = 1'b0;
    cs_o        = 1'b0;
    serial_in_o = 1'b0;
    got_stb_o   = 1'b0;
    got_bit_o   = 1'b0;
  end

  // A real host may stall its clock at either level
  task automatic pause();
    if ($urandom_range(7) == 0)
      #($urandom_range(150, 1));
  endtask : pause

  task automatic set_cs(input logic v);
    cs_o <= v;
  endtask : set_cs

  // Sends n bits of v MSB first, then nrd further edges with data in toggling
  task automatic frame(input logic [26:0] v, input int n, input int nrd);
    int pre;
    pre = $urandom_range(3);
    cs_o <= 1'b1;
    #60;
    for (int i = 0; i < pre + n + nrd; i++)
    begin
      serial_in_o <= (i < pre) ? 1'b0 : (i < pre + n) ? v[pre + n - 1 - i] : ~serial_in_o;
      #23;
      sclk_o <= 1'b1;
      pause();
      #24;
      if (nrd > 0 && i >= pre + n - 1)
      begin
        got_bit_o <= pin_i;
        got_stb_o <= 1'b1;
      end
      sclk_o <= 1'b0;
      pause();
      #1;
      got_stb_o <= 1'b0;
    end
    // Select stays up long enough for the done flag to cross
    #100;
    cs_o <= 1'b0;
    #300;
    serial_in_o <= ~serial_in_o;
  endtask : frame
endmodule : serial_host_model

// >>> tb_serial_eeprom_program_control.sv
// Bench for the EEPROM controller: host model on the pins, queue-based checking
// Assumes serial_eeprom_map.svh is on the include path
`timescale 1ns/1ps
`include "serial_eeprom_map.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t ns: got %h expected %h", $time, (a), (e)); end end
module tb_serial_eeprom_program_control;
  localparam int unsigned WORD_C = 40;
  localparam int unsigned ERASE_ALL_CMD_C = 60;
  localparam int unsigned WRITE_ALL_CMD_C = 80;
  logic        ref_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        word_size_sel_i = 1'b1;
  logic        sclk, cs, sdi, pin, out, oe, got_stb, got_bit, en_m;
  logic [15:0] mem [256];
  logic        exp_q [$];
  int          error_cnt = 0;
  int          check_count = 0;

  // ----------------------------------------------------------------
  // Clock, pin resolution, instances
  // ----------------------------------------------------------------
  always #12.5 ref_clk_i = ~ref_clk_i;
  // Pull-up on the data pin, so a ready after release still reads high
  assign pin = oe ? out : 1'b1;

  serial_eeprom_program_control #(.WORD_CYC(WORD_C), .ERASE_ALL_CMD_CYC(ERASE_ALL_CMD_C), .WRITE_ALL_CMD_CYC(WRITE_ALL_CMD_C)) dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_i(cs), .serial_in_i(sdi),
    .word_size_sel_i(word_size_sel_i), .serial_out_o(out), .serial_out_oe_o(oe));
  serial_host_model host (.sclk_o(sclk), .cs_o(cs), .serial_in_o(sdi), .pin_i(pin),
    .got_stb_o(got_stb), .got_bit_o(got_bit));

  always @(posedge got_stb)
  begin
    if (exp_q.size() == 0)
      `CHK(1'b1, 1'b0)
    else
      `CHK(got_bit, exp_q.pop_front())
  end

  // ----------------------------------------------------------------
  // Reference array and instruction tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] get(input logic [8:0] a);
    if (word_size_sel_i)
      return mem[a[7:0]];
    return a[0] ? {8'h00, mem[a[8:1]][15:8]} : {8'h00, mem[a[8:1]][7:0]};
  endfunction : get

  task automatic put(input logic [8:0] a, input logic [15:0] d);
    if (word_size_sel_i)
      mem[a[7:0]] = d;
    else if (a[0])
      mem[a[8:1]][15:8] = d[7:0];
    else
      mem[a[8:1]][7:0] = d[7:0];
  endtask : put

  function automatic logic [8:0] sp(input logic [1:0] s);
    return word_size_sel_i ? {1'b0, s, 6'h00} : {s, 7'h00};
  endfunction : sp

  task automatic instr(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d,
                       input int nw);
    int          w, n, cyc, k, el;
    logic [26:0] v;
    logic [8:0]  b;
    logic [1:0]  sub;
    logic [15:0] u;
    logic        prog;
    realtime     t0;
    w   = word_size_sel_i ? 16 : 8;
    n   = word_size_sel_i ? 11 : 12;
    v   = word_size_sel_i ? 27'({1'b1, op, a[7:0]}) : 27'({1'b1, op, a});
    sub = word_size_sel_i ? a[7:6] : a[8:7];
    if (op == `EE_OP_WRITE || (op == `EE_OP_SPECIAL && sub == `EE_SUB_WR_ALL))
    begin
      v = (v << w) | (word_size_sel_i ? 27'(d) : 27'(d[7:0]));
      n = n + w;
    end
    if (op == `EE_OP_READ)
    begin
      exp_q.push_back(1'b0);
      b = a;
      for (int q = 0; q < nw; q++)
      begin
        u = get(b);
        for (int j = w - 1; j >= 0; j--)
          exp_q.push_back(u[j]);
        b = word_size_sel_i ? {1'b0, b[7:0] + 8'h01} : b + 9'h001;
      end
    end
    host.frame(v, n, (op == `EE_OP_READ) ? nw * w : 0);
    t0   = $realtime - 300.0;
    prog = (op != `EE_OP_READ) && !(op == `EE_OP_SPECIAL && sub[0] == sub[1]);
    if (op == `EE_OP_SPECIAL && sub == `EE_SUB_ENABLE)
      en_m = 1'b1;
    if (op == `EE_OP_SPECIAL && sub == `EE_SUB_DISABLE)
      en_m = 1'b0;
    if (prog)
    begin
      cyc = (op != `EE_OP_SPECIAL) ? WORD_C : (sub == `EE_SUB_ER_ALL) ? ERASE_ALL_CMD_C : WRITE_ALL_CMD_C;
      if (en_m && op == `EE_OP_ERASE)
        put(a, 16'hffff);
      if (en_m && op == `EE_OP_WRITE)
        put(a, d);
      for (int m = 0; m < 256 && en_m && op == `EE_OP_SPECIAL; m++)
        mem[m] = (sub == `EE_SUB_ER_ALL) ? 16'hffff : word_size_sel_i ? d : {d[7:0], d[7:0]};
      host.set_cs(1'b1);
      repeat (5) @(posedge ref_clk_i);
      #1;
      `CHK(oe, en_m)
      if (en_m)
      begin
        `CHK(out, 1'b0)
        k = 0;
        while (out !== 1'b1 && k < 2000)
        begin
          @(posedge ref_clk_i);
          #1;
          k++;
        end
        if (k == 2000)
        begin
          error_cnt++;
          finish_test();
        end
        el = int'(($realtime - t0) / 25.0);
        `CHK(el >= cyc && el <= cyc + 12, 1'b1)
        `CHK(oe, 1'b1)
      end
      host.set_cs(1'b0);
      #300;
    end
  endtask : instr

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Main sequence: x16 pass, then a second reset into x8
  // ----------------------------------------------------------------
  initial
  begin
    logic [8:0]  a;
    logic [8:0]  last;
    logic [15:0] d;
    void'($urandom(32'ha0186205));
    for (int p = 0; p < 2; p++)
    begin
      @(posedge ref_clk_i);
      reset_i <= 1'b1;
      if (p == 1)
        word_size_sel_i <= 1'b0;
      repeat (12) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      foreach (mem[m])
        mem[m] = 16'hffff;
      en_m = 1'b0;
      last = word_size_sel_i ? 9'h0ff : 9'h1ff;
      a    = 9'($urandom_range(int'(last) - 1));
      d    = 16'($urandom);
      instr(`EE_OP_READ, a, 16'h0000, 1);
      instr(`EE_OP_WRITE, a, d, 0);
      instr(`EE_OP_SPECIAL, sp(`EE_SUB_ER_ALL), 16'h0000, 0);
      instr(`EE_OP_SPECIAL, sp(`EE_SUB_ENABLE), 16'h0000, 0);
      instr(`EE_OP_WRITE, a, d, 0);
      instr(`EE_OP_READ, a, 16'h0000, 2);
      instr(`EE_OP_ERASE, a, 16'h0000, 0);
      instr(`EE_OP_READ, a, 16'h0000, 1);
      instr(`EE_OP_SPECIAL, sp(`EE_SUB_WR_ALL), ~d, 0);
      instr(`EE_OP_READ, last, 16'h0000, 2);
      instr(`EE_OP_SPECIAL, sp(`EE_SUB_ER_ALL), 16'h0000, 0);
      instr(`EE_OP_READ, a, 16'h0000, 1);
      instr(`EE_OP_SPECIAL, sp(`EE_SUB_DISABLE), 16'h0000, 0);
      instr(`EE_OP_WRITE, a, d, 0);
      instr(`EE_OP_READ, a, 16'h0000, 1);
    end
    `CHK(exp_q.size(), 0)
    finish_test();
  end

  initial
  begin
    #1ms;
    error_cnt++;
    finish_test();
  end
endmodule : tb_serial_eeprom_program_control
